// [pkg/ssr_map.svh]
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
// Register byte addresses
`define SSR_OFS_RCSC  8'h00
`define SSR_OFS_TXSC  8'h04
`define SSR_OFS_BAUD  8'h08
`define SSR_OFS_DIVH  8'h0C
`define SSR_OFS_DIVL  8'h10
`define SSR_OFS_RCDR  8'h14
`define SSR_OFS_TXDR  8'h18
`define SSR_OFS_IEN   8'h1C
// receive_status_control fields
`define SSR_B_PORT_ENABLE    7
`define SSR_B_RX9     6
`define SSR_B_SINGLE_SHOT_RECEIVE_ENABLE    5
`define SSR_B_CONTINUOUS_RECEIVE_ENABLE    4
`define SSR_B_FRAMING_ERROR_FLAG    2
`define SSR_B_OVERRUN_ERROR_FLAG    1
`define SSR_B_RECEIVED_NINTH_BIT    0
// transmit_status_control fields
`define SSR_B_MASTER_CLOCK_SOURCE    7
`define SSR_B_SYNC    4
// baud_control fields
`define SSR_B_DATA_POLARITY_SELECT   5
`define SSR_B_CLOCK_POLARITY_SELECT   4
// Interrupt enable field
`define SSR_B_RECEIVE_INTERRUPT_ENABLE    0
// Character lengths, last bit index
`define SSR_LAST8     4'h7
`define SSR_LAST9     4'h8
`define SSR_FIFO_FULL 2'h2
`define SSR_RST_BYTE  8'h00
`define SSR_RST_DIV   16'h0000
`define SSR_RESP_OK   2'b00
`define SSR_RESP_ERR  2'b10
`endif

// [pkg/ssr_pkg.sv]
package ssr_pkg;
  // Receive clock engine state
  typedef enum logic [1:0] {
    SSR_OFF    = 2'b00,
    SSR_IDLEPH = 2'b01,
    SSR_ACTPH  = 2'b10
  } ssr_state_e;
  // One received character
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } ssr_char_s;
endpackage

// [rtl/ssr_sync_rx.sv]
// Notes on behaviour
// - Reception starts when single-shot or continuous receive enable is set.
// - Single-shot alone in master mode: one clock per bit of one character, then enable self-clears.
// - Continuous enable set: shift clocks run without pause until cleared or until an overrun.
// - Continuous cleared mid-character: clock stops at once, partial character dropped.
// - Both enables set in master mode: single-shot clears after first character, continuous goes on.
// - Data line sampled at each trailing clock edge into the shift register.
// - Full character sets pending flag and moves into two-deep receive FIFO.
// - Receive data register shows low eight bits of the oldest FIFO entry.
// - Pending flag stays set while any unread character sits in the FIFO.
// - Slave mode clocks from the clock pin, one data bit per clock cycle.
// - Driver changes data on leading edge so it is stable at trailing edge.
// - Third complete character with FIFO full sets overrun, FIFO kept intact.
// - During overrun both entries stay readable and no character is accepted.
// - Overrun taken in single-shot mode clears on a receive data read.
// - Overrun in continuous mode clears only by dropping continuous or port enable.
// - Nine-bit select shifts nine bits; ninth bit field shows oldest entry's MSB.
// - Pending flag with receive interrupt enable raises the interrupt request.
// - Master drives the shift clock on the clock pin, one cycle per bit.
// - Polarity set: idle high, sample rising; clear: idle low, sample falling.
// - Data polarity select resets to zero; one inverts received data.
// - Master clock source set makes us master; clear makes us a slave.
`timescale 1ns/1ns
`default_nettype none
`include "ssr_map.svh"

module ssr_sync_rx #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire  logic              core_clk_i,
  input  wire  logic              sys_rst_i,
  // AXI4-Lite write address
  input  wire  logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire  logic              s_axi_awvalid,
  output logic                    s_axi_awready,
  // AXI4-Lite write data
  input  wire  logic [31:0]       s_axi_wdata,
  input  wire  logic [3:0]        s_axi_wstrb,
  input  wire  logic              s_axi_wvalid,
  output logic                    s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire  logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire  logic [ADDR_W-1:0] s_axi_araddr,
  input  wire  logic              s_axi_arvalid,
  output logic                    s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire  logic              s_axi_rready,
  // Data line pin
  input  wire  logic              data_line_pin_i,
  output logic                    data_line_pin_o,
  output logic                    data_line_pin_oe_n_o,
  // Clock line pin
  input  wire  logic              clock_line_pin_i,
  output logic                    clock_line_pin_o,
  output logic                    clock_line_pin_oe_n_o,
  // Status
  output logic                    rx_pending_o,
  output logic                    rx_irq_o
);
  import ssr_pkg::*;

  // Control registers
  logic        port_enable;
  logic        nine_bit_receive_select;
  logic        single_shot_receive_enable;
  logic        continuous_receive_enable;
  logic        master_clock_source;
  logic        sync_select;
  logic        data_polarity_select;
  logic        clock_polarity_select;
  logic [7:0]  baud_divisor_high;
  logic [7:0]  baud_divisor_low;
  logic        receive_interrupt_enable;

  // Bus slave state
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0]        w_byte;
  logic              w_lane0;

  // Receive state
  ssr_state_e  state;
  ssr_state_e  next_state;
  logic [15:0] div_cnt;
  logic [3:0]  bit_cnt;
  logic [7:0]  receive_shift_register;
  ssr_char_s   fifo_mem [0:1];
  logic        rd_ptr;
  logic [1:0]  fifo_cnt;
  logic        overrun_error_flag;
  logic        overrun_error_flag_single;
  logic [2:0]  pin_s0;
  logic [2:0]  pin_s1;
  logic [2:0]  pin_s2;
  logic        data_f;
  logic        ck_f;
  logic        ck_prev;
  logic        clk_q;

  // Bus decode
  wire aw_hs    = s_axi_awvalid & s_axi_awready;
  wire w_hs     = s_axi_wvalid & s_axi_wready;
  wire ar_hs    = s_axi_arvalid & s_axi_arready;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_en    = do_write & w_lane0;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a[7:0] == ofs);
  endfunction

  wire wr_rcsc = wr_en & hit(aw_addr, `SSR_OFS_RCSC);
  wire wr_txsc = wr_en & hit(aw_addr, `SSR_OFS_TXSC);
  wire wr_baud = wr_en & hit(aw_addr, `SSR_OFS_BAUD);
  wire wr_divh = wr_en & hit(aw_addr, `SSR_OFS_DIVH);
  wire wr_divl = wr_en & hit(aw_addr, `SSR_OFS_DIVL);
  wire wr_ien  = wr_en & hit(aw_addr, `SSR_OFS_IEN);
  wire w_map   = hit(aw_addr, `SSR_OFS_RCSC) | hit(aw_addr, `SSR_OFS_TXSC)
               | hit(aw_addr, `SSR_OFS_BAUD) | hit(aw_addr, `SSR_OFS_DIVH)
               | hit(aw_addr, `SSR_OFS_DIVL) | hit(aw_addr, `SSR_OFS_TXDR)
               | hit(aw_addr, `SSR_OFS_IEN);
  wire r_map   = hit(s_axi_araddr, `SSR_OFS_RCSC) | hit(s_axi_araddr, `SSR_OFS_TXSC)
               | hit(s_axi_araddr, `SSR_OFS_BAUD) | hit(s_axi_araddr, `SSR_OFS_DIVH)
               | hit(s_axi_araddr, `SSR_OFS_DIVL) | hit(s_axi_araddr, `SSR_OFS_RCDR)
               | hit(s_axi_araddr, `SSR_OFS_TXDR) | hit(s_axi_araddr, `SSR_OFS_IEN);
  wire rd_rcdr = ar_hs & hit(s_axi_araddr, `SSR_OFS_RCDR);

  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;

  // Receive control decode
  wire        rx_rst   = sys_rst_i | ~port_enable;
  wire        rx_req   = single_shot_receive_enable | continuous_receive_enable;
  wire        sync_on  = port_enable & sync_select;
  wire        m_go     = sync_on & master_clock_source & rx_req & ~overrun_error_flag;
  wire        s_on     = sync_on & ~master_clock_source & rx_req & ~overrun_error_flag;
  wire        tick     = (div_cnt == `SSR_RST_DIV);
  wire [15:0] divisor  = {baud_divisor_high, baud_divisor_low};
  wire        m_take   = (state == SSR_ACTPH) & tick & m_go;
  wire        s_trail  = (ck_f == clock_polarity_select) & (ck_prev != clock_polarity_select);
  wire        s_take   = s_on & s_trail;
  wire        bit_take = m_take | s_take;
  wire        rx_bit   = data_f ^ data_polarity_select;
  wire [3:0]  last_idx = nine_bit_receive_select ? `SSR_LAST9 : `SSR_LAST8;
  wire        char_done = bit_take & (bit_cnt == last_idx);
  wire        keep     = master_clock_source ? (state != SSR_OFF) : s_on;
  wire        fifo_full = (fifo_cnt == `SSR_FIFO_FULL);
  wire        push     = char_done & ~fifo_full;
  wire        pop      = rd_rcdr & (fifo_cnt != 2'h0);
  wire        ovr_set  = char_done & fifo_full;
  wire        wr_idx   = rd_ptr ^ fifo_cnt[0];
  ssr_char_s  head;
  ssr_char_s  new_char;

  // Empty FIFO reads as zero, never as stale or unwritten entries
  assign head = (fifo_cnt != 2'h0) ? fifo_mem[rd_ptr] : '0;
  // Eight-bit characters put the last bit at bit 7 and leave the ninth bit clear
  assign new_char = nine_bit_receive_select ? {rx_bit, receive_shift_register} : {1'b0, rx_bit, receive_shift_register[6:0]};

  // Master clock engine
  always_comb begin
    next_state = state;
    case (state)
      SSR_OFF: begin
        if (m_go) begin
          next_state = SSR_IDLEPH;
        end
      end
      SSR_IDLEPH: begin
        if (!m_go) begin
          next_state = SSR_OFF;
        end else if (tick) begin
          next_state = SSR_ACTPH;
        end
      end
      SSR_ACTPH: begin
        if (!m_go) begin
          next_state = SSR_OFF;
        end else if (tick) begin
          next_state = SSR_IDLEPH;
        end
      end
      default: begin
        next_state = SSR_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rx_rst) begin
      state   <= SSR_OFF;
      div_cnt <= `SSR_RST_DIV;
    end else begin
      state <= next_state;
      if (state == SSR_OFF || tick) begin
        div_cnt <= divisor;
      end else begin
        div_cnt <= div_cnt - 16'h0001;
      end
    end
  end

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pin_s0  <= 3'h0;
      pin_s1  <= 3'h0;
      pin_s2  <= 3'h0;
      data_f  <= 1'b0;
      ck_f    <= 1'b0;
      ck_prev <= 1'b0;
    end else begin
      pin_s0  <= {1'b0, clock_line_pin_i, data_line_pin_i};
      pin_s1  <= pin_s0;
      pin_s2  <= pin_s1;
      ck_prev <= ck_f;
      if (pin_s1[0] == pin_s2[0]) begin
        data_f <= pin_s2[0];
      end
      if (pin_s1[1] == pin_s2[1]) begin
        ck_f <= pin_s2[1];
      end
    end
  end

  // Shift register and bit counter
  always_ff @(posedge core_clk_i) begin
    if (rx_rst || !keep) begin
      bit_cnt <= 4'h0;
      receive_shift_register     <= `SSR_RST_BYTE;
    end else if (bit_take) begin
      receive_shift_register[bit_cnt[2:0]] <= rx_bit;
      if (char_done) begin
        bit_cnt <= 4'h0;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // Two-deep FIFO; a push and a pop in one cycle leave the count unchanged
  always_ff @(posedge core_clk_i) begin
    if (rx_rst) begin
      rd_ptr   <= 1'b0;
      fifo_cnt <= 2'h0;
    end else begin
      if (push) begin
        fifo_mem[wr_idx] <= new_char;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // Overrun flag; it is only set while clear, so set never meets its own clear
  always_ff @(posedge core_clk_i) begin
    if (rx_rst) begin
      overrun_error_flag <= 1'b0;
      overrun_error_flag_single        <= 1'b0;
    end else if (ovr_set) begin
      overrun_error_flag <= 1'b1;
      overrun_error_flag_single        <= ~continuous_receive_enable;
    end else if (overrun_error_flag_single && rd_rcdr) begin
      overrun_error_flag <= 1'b0;
    end else if (!overrun_error_flag_single && !continuous_receive_enable) begin
      overrun_error_flag <= 1'b0;
    end
  end

  // Clock pin output is registered from the next engine state
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= clock_polarity_select ^ (next_state == SSR_ACTPH);
    end
  end

  assign clock_line_pin_o      = clk_q;
  assign clock_line_pin_oe_n_o = ~(sync_on & master_clock_source);
  // Receive path never drives the data line
  assign data_line_pin_o       = 1'b0;
  assign data_line_pin_oe_n_o  = 1'b1;
  assign rx_pending_o          = (fifo_cnt != 2'h0);
  assign rx_irq_o              = rx_pending_o & receive_interrupt_enable;

  // Control registers; a software write of the single-shot enable beats its self-clear
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      port_enable                <= 1'b0;
      nine_bit_receive_select    <= 1'b0;
      single_shot_receive_enable <= 1'b0;
      continuous_receive_enable  <= 1'b0;
      master_clock_source        <= 1'b0;
      sync_select                <= 1'b0;
      data_polarity_select       <= 1'b0;
      clock_polarity_select      <= 1'b0;
      baud_divisor_high          <= `SSR_RST_BYTE;
      baud_divisor_low           <= `SSR_RST_BYTE;
      receive_interrupt_enable   <= 1'b0;
    end else begin
      if (wr_rcsc) begin
        port_enable                <= w_byte[`SSR_B_PORT_ENABLE];
        nine_bit_receive_select    <= w_byte[`SSR_B_RX9];
        single_shot_receive_enable <= w_byte[`SSR_B_SINGLE_SHOT_RECEIVE_ENABLE];
        continuous_receive_enable  <= w_byte[`SSR_B_CONTINUOUS_RECEIVE_ENABLE];
      end else if (char_done && master_clock_source) begin
        single_shot_receive_enable <= 1'b0;
      end
      if (wr_txsc) begin
        master_clock_source <= w_byte[`SSR_B_MASTER_CLOCK_SOURCE];
        sync_select         <= w_byte[`SSR_B_SYNC];
      end
      if (wr_baud) begin
        data_polarity_select  <= w_byte[`SSR_B_DATA_POLARITY_SELECT];
        clock_polarity_select <= w_byte[`SSR_B_CLOCK_POLARITY_SELECT];
      end
      if (wr_divh) begin
        baud_divisor_high <= w_byte;
      end
      if (wr_divl) begin
        baud_divisor_low <= w_byte;
      end
      if (wr_ien) begin
        receive_interrupt_enable <= w_byte[`SSR_B_RECEIVE_INTERRUPT_ENABLE];
      end
    end
  end

  // Read data selection; framing error does not exist in synchronous mode
  logic [7:0] rcsc_rd;
  logic [7:0] txsc_rd;
  logic [7:0] baud_rd;
  logic [7:0] ien_rd;
  logic [7:0] rd_byte;

  always_comb begin
    rcsc_rd = `SSR_RST_BYTE;
    txsc_rd = `SSR_RST_BYTE;
    baud_rd = `SSR_RST_BYTE;
    ien_rd  = `SSR_RST_BYTE;
    rcsc_rd[`SSR_B_PORT_ENABLE] = port_enable;
    rcsc_rd[`SSR_B_RX9]  = nine_bit_receive_select;
    rcsc_rd[`SSR_B_SINGLE_SHOT_RECEIVE_ENABLE] = single_shot_receive_enable;
    rcsc_rd[`SSR_B_CONTINUOUS_RECEIVE_ENABLE] = continuous_receive_enable;
    rcsc_rd[`SSR_B_FRAMING_ERROR_FLAG] = 1'b0;
    rcsc_rd[`SSR_B_OVERRUN_ERROR_FLAG] = overrun_error_flag;
    rcsc_rd[`SSR_B_RECEIVED_NINTH_BIT] = head.ninth;
    txsc_rd[`SSR_B_MASTER_CLOCK_SOURCE] = master_clock_source;
    txsc_rd[`SSR_B_SYNC] = sync_select;
    baud_rd[`SSR_B_DATA_POLARITY_SELECT] = data_polarity_select;
    baud_rd[`SSR_B_CLOCK_POLARITY_SELECT] = clock_polarity_select;
    ien_rd[`SSR_B_RECEIVE_INTERRUPT_ENABLE]   = receive_interrupt_enable;
  end

  assign rd_byte = hit(s_axi_araddr, `SSR_OFS_RCSC) ? rcsc_rd :
                   hit(s_axi_araddr, `SSR_OFS_TXSC) ? txsc_rd :
                   hit(s_axi_araddr, `SSR_OFS_BAUD) ? baud_rd :
                   hit(s_axi_araddr, `SSR_OFS_DIVH) ? baud_divisor_high :
                   hit(s_axi_araddr, `SSR_OFS_DIVL) ? baud_divisor_low :
                   hit(s_axi_araddr, `SSR_OFS_RCDR) ? head.data :
                   hit(s_axi_araddr, `SSR_OFS_IEN)  ? ien_rd :
                   `SSR_RST_BYTE;

  // AXI4-Lite write side: address and data are taken in either order
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_byte       <= `SSR_RST_BYTE;
      w_lane0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SSR_RESP_OK;
    end else begin
      if (aw_hs) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_map ? `SSR_RESP_OK : `SSR_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read side; a receive data read pops the FIFO as it is taken
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SSR_RESP_OK;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= r_map ? `SSR_RESP_OK : `SSR_RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ssr_sync_rx
`default_nettype wire

// [bench/ssr_sync_rx_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module ssr_sync_rx_checker #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  // Register bus
  input  wire logic              s_axi_awvalid,
  input  wire logic              s_axi_awready,
  input  wire logic              s_axi_wvalid,
  input  wire logic              s_axi_wready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [31:0]       s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins and status
  input  wire logic              data_line_pin_oe_n_o,
  input  wire logic              rx_pending_o,
  input  wire logic              rx_irq_o
);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_pop  = ar_take && (s_axi_araddr == 8'h14);
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  data_undriven_a:
    assert property (data_line_pin_oe_n_o) else $error("data line driven");
  irq_needs_pending_a:
    assert property (rx_irq_o |-> rx_pending_o) else $error("irq without pending");
  pending_fall_cause_a:
    assert property ($fell(rx_pending_o) |-> $past(rd_pop) || $past(rd_pop, 2) || s_axi_bvalid
                     || $past(s_axi_bvalid) || $past(sys_rst_i)) else $error("pending dropped");
  rd_answer_a:
    assert property (ar_take |=> s_axi_rvalid) else $error("read answer late");
  rd_unmapped_a:
    assert property (ar_take && s_axi_araddr >= 8'h20 |=> s_axi_rresp == 2'b10) else $error("unmapped rresp");
  rd_byte_only_a:
    assert property (s_axi_rvalid && s_axi_rresp == 2'b00 |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("rdata upper bits set");
  wr_answer_a:
    assert property (wr_take |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  b_stands_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bvalid dropped");
  r_stands_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rvalid dropped");
endmodule // ssr_sync_rx_checker
bind ssr_sync_rx ssr_sync_rx_checker #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk_i, .sys_rst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_line_pin_oe_n_o,
  .rx_pending_o, .rx_irq_o
);
`default_nettype wire

// [bench/ssr_peer.sv]
`timescale 1ns/1ns
`default_nettype none
module ssr_peer (
  // Link from the device
  input  wire logic dev_clk_i,
  input  wire logic pol_i,
  // Link toward the device
  output logic      data_o,
  output logic      clk_o
);
  logic [26:0] bits;
  int          left;
  logic        own_clk;
  initial begin
    own_clk = 1'b0;
    data_o = 1'b0;
    clk_o  = 1'b0;
    bits   = '0;
    left   = 0;
  end
  task automatic load(input logic [26:0] v, input int n);
    bits = v;
    left = n;
  endtask
  // Slave side: a new bit on each leading edge, settled by the trailing edge
  always @(dev_clk_i) begin
    // Quiet while this model makes the clock itself, or it would overwrite its own bits
    if (!own_clk && dev_clk_i !== pol_i) begin
      if (left > 0) begin
        data_o = bits[0];
        bits   = bits >> 1;
        left   = left - 1;
      end else begin
        data_o = ~data_o; // Out of data: never a stale level
      end
    end
  end
  // Master side: exactly n clocks at 160 ns, off the core clock's phase
  task automatic clock_char(input logic [8:0] v, input int n);
    own_clk = 1'b1;
    #3;
    for (int i = 0; i < n; i++) begin
      clk_o  = ~pol_i;
      data_o = v[i];
      #80;
      clk_o = pol_i;
      #80;
    end
    data_o  = ~data_o;
    own_clk = 1'b0;
  endtask
endmodule // ssr_peer
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        core_clk_i, sys_rst_i, pol, prev_ck;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        data_line_pin_o, data_line_pin_oe_n_o, clock_line_pin_o, clock_line_pin_oe_n_o;
  logic        rx_pending_o, rx_irq_o, peer_d, peer_ck;
  wire         dl_w = data_line_pin_oe_n_o ? peer_d : data_line_pin_o;
  wire         ck_w = clock_line_pin_oe_n_o ? peer_ck : clock_line_pin_o;
  int          fail_count, n_tests, lead_n, b, t, cyc;
  ssr_sync_rx dut (.core_clk_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .data_line_pin_i(dl_w), .data_line_pin_o, .data_line_pin_oe_n_o, .clock_line_pin_i(ck_w),
    .clock_line_pin_o, .clock_line_pin_oe_n_o, .rx_pending_o, .rx_irq_o);
  ssr_peer peer (.dev_clk_i(ck_w), .pol_i(pol), .data_o(peer_d), .clk_o(peer_ck));
  always #4 core_clk_i = ~core_clk_i;
  // Leading edges of the shift clock, counted as the core clock sees them
  always @(posedge core_clk_i) begin
    prev_ck <= ck_w;
    if (prev_ck !== ck_w && ck_w !== pol) lead_n <= lead_n + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("mismatches %0d of %0d comparisons", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk("rdata", {24'h00_0000, e}, d);
    chk("rresp", 32'h0000_0000, {30'h0000_0000, r});
  endtask
  task automatic wait_pend();
    t = 0;
    while (rx_pending_o !== 1'b1 && t < 3000) begin
      @(posedge core_clk_i);
      t++;
    end
    chk1("pending", 1'b1, rx_pending_o);
  endtask
  initial begin
    {core_clk_i, pol, prev_ck, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {fail_count, n_tests, lead_n, cyc} = '0;
    sys_rst_i = 1'b1;
    repeat (20) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rdc(8'h00, 8'h00);
    rdc(8'h08, 8'h00);
    rd(8'h20);
    chk("rresp", 32'h0000_0002, {30'h0000_0000, r});
    wr(8'h24, 8'hFF);
    chk("bresp", 32'h0000_0002, {30'h0000_0000, r});
    // Master, single shot, eight bits
    wr(8'h10, 8'h04);
    wr(8'h04, 8'h90);
    chk1("ck idle", 1'b0, clock_line_pin_o);
    peer.load(27'h000_00A5, 8);
    b = lead_n;
    wr(8'h00, 8'hA0);
    chk1("ck oe_n", 1'b0, clock_line_pin_oe_n_o);
    wait_pend();
    repeat (100) @(posedge core_clk_i);
    chk("clocks", 32'(lead_n - b), 32'h0000_0008);
    chk1("irq masked", 1'b0, rx_irq_o);
    rdc(8'h00, 8'h80);
    rdc(8'h14, 8'hA5);
    chk1("pending", 1'b0, rx_pending_o);
    // Continuous, nine bits, idle-high clock, overrun
    wr(8'h00, 8'h00);
    pol = 1'b1;
    wr(8'h08, 8'h10);
    wr(8'h1C, 8'h01);
    repeat (4) @(posedge core_clk_i);
    chk1("ck idle", 1'b1, clock_line_pin_o);
    peer.load({9'h155, 9'h0C3, 9'h13C}, 27);
    wr(8'h00, 8'hD0);
    wait_pend();
    chk1("irq", 1'b1, rx_irq_o);
    for (int i = 0; i < 200 && d[1] !== 1'b1; i++) rd(8'h00);
    b = lead_n;
    repeat (60) @(posedge core_clk_i);
    chk("clocks held", 32'(lead_n - b), 32'h0000_0000);
    rdc(8'h00, 8'hD3);
    rdc(8'h14, 8'h3C);
    chk1("pending", 1'b1, rx_pending_o);
    rdc(8'h00, 8'hD2);
    rdc(8'h14, 8'hC3);
    chk1("irq", 1'b0, rx_irq_o);
    rdc(8'h00, 8'hD2);
    wr(8'h00, 8'hC0);
    rdc(8'h00, 8'hC0);
    // Continuous dropped mid-character, then two clean single shots
    peer.load(27'h000_00FF, 8);
    b = lead_n;
    wr(8'h00, 8'h90);
    for (t = 0; t < 500 && lead_n - b < 3; t++) @(posedge core_clk_i);
    wr(8'h00, 8'h80);
    b = lead_n;
    repeat (60) @(posedge core_clk_i);
    chk("clocks stop", 32'(lead_n - b), 32'h0000_0000);
    chk1("ck idle", 1'b1, clock_line_pin_o);
    chk1("pending", 1'b0, rx_pending_o);
    peer.load(27'h000_005A, 8);
    wr(8'h00, 8'hA0);
    wait_pend();
    rdc(8'h14, 8'h5A);
    peer.load(27'h000_0033, 8);
    wr(8'h00, 8'hA0);
    wait_pend();
    // Two more single shots unread: the third one overruns
    peer.load(27'h000_0044, 8);
    wr(8'h00, 8'hA0);
    repeat (150) @(posedge core_clk_i);
    peer.load(27'h000_0055, 8);
    wr(8'h00, 8'hA0);
    repeat (150) @(posedge core_clk_i);
    rdc(8'h00, 8'h82);
    rdc(8'h14, 8'h33);
    rdc(8'h00, 8'h80);
    wr(8'h00, 8'h00);
    repeat (2) @(posedge core_clk_i);
    chk1("pending", 1'b0, rx_pending_o);
    // Slave, clock from outside, inverted data
    pol = 1'b0;
    wr(8'h08, 8'h20);
    wr(8'h04, 8'h10);
    wr(8'h00, 8'h90);
    chk1("ck oe_n", 1'b1, clock_line_pin_oe_n_o);
    peer.clock_char(9'h05A, 8);
    wait_pend();
    rdc(8'h14, 8'hA5);
    test_done();
  end
endmodule // tb
`default_nettype wire
